// file: include/epp_pkg.sv
// Package: constants and carriers for the EPP cycle engine
package epp_pkg;
   localparam int CLK_HZ = 10_000_000;
   localparam int WDOG_US = 10;
   localparam int WDOG_CYCLES = (WDOG_US * CLK_HZ) / 1_000_000;
   localparam logic [2:0] OFS_EPP_ADDR = 3'h3;
   localparam logic [2:0] OFS_EPP_DATA_LO = 3'h4;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam int CTRL_STROBE = 0;
   localparam int CTRL_AUTOFD = 1;
   localparam int CTRL_INIT = 2;
   localparam int CTRL_SLCTIN = 3;
   localparam int CTRL_DIR = 5;
   localparam int FIFO_WIDTH = 9;
   localparam int FIFO_DEPTH = 32;
   localparam int WDOG_W = 8;

   typedef enum logic {TIMING_19, TIMING_17} timing_t;

   // One finished cycle: read data plus address flag
   typedef struct packed {
      logic is_addr;
      logic [7:0] data;
   } xfer_t;

   // Host request presented by the host bus decoder
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] offset;
      logic [7:0] wdata;
   } host_req_t;
endpackage

// file: hw/epp_cycle_engine.sv
// EPP cycle engine with a FIFO of completed read cycles
`timescale 1ns/100ps
`default_nettype none

module epp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 32
) (
   input wire logic clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready_out = (count != (AW+1)'(DEPTH));
   assign out_valid_out = (count != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr];

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

module epp_cycle_engine (
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration and control register bits
   input wire logic epp_enable_in,
   input wire epp_pkg::timing_t timing_sel_in,
   input wire logic [5:0] ctrl_reg_in,
   input wire logic [7:0] spp_data_in,
   input wire logic timeout_clear_in,
   output logic timeout_flag_out,
   // Host bus
   input wire epp_pkg::host_req_t host_req_in,
   output logic iochrdy_out,
   output logic [7:0] host_data_bus_out,
   // Peripheral link
   input wire logic wait_n_in,
   input wire logic intr_in,
   output logic intr_out,
   output logic write_n_out,
   output logic data_strobe_n_out,
   output logic addr_strobe_n_out,
   output logic port_dir_out,
   output logic init_n_out,
   output logic strobe_n_out,
   output logic autofd_n_out,
   output logic slctin_n_out,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_out,
   output logic port_data_oe_out,
   // Completed transfers
   output logic xfer_valid_out,
   input wire logic xfer_ready_in,
   output epp_pkg::xfer_t xfer_out
);
   typedef enum logic [2:0] {
      IDLE, WAIT_LOW, STROBE, HOLD, DONE
   } state_t;

   state_t state;
   logic cyc_write;
   logic cyc_addr;
   logic [7:0] latch_data;
   logic [epp_pkg::WDOG_W-1:0] wdog;
   logic wdog_expired;
   logic strobe_on;
   logic host_active;
   logic start;
   logic fifo_ready;
   logic push;
   logic [7:0] rd_capture;

   // Every offset from the address port upward starts a cycle
   function automatic logic is_epp_offset(input logic [2:0] ofs);
      return ofs >= epp_pkg::OFS_EPP_ADDR;
   endfunction

   assign host_active = host_req_in.rd || host_req_in.wr;
   assign start = epp_enable_in && host_active &&
                  is_epp_offset(host_req_in.offset) && fifo_ready;
   assign wdog_expired = (wdog >= epp_pkg::WDOG_W'(epp_pkg::WDOG_CYCLES));

   // Cycle sequencer
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state <= IDLE;
         cyc_write <= 1'b0;
         cyc_addr <= 1'b0;
      end else begin
         case (state)
            IDLE: begin
               if (start) begin
                  cyc_write <= host_req_in.wr;
                  cyc_addr <= (host_req_in.offset == epp_pkg::OFS_EPP_ADDR);
                  if (timing_sel_in == epp_pkg::TIMING_17) begin
                     state <= STROBE;
                  end else begin
                     state <= WAIT_LOW;
                  end
               end
            end
            WAIT_LOW: begin
               if (wdog_expired) begin
                  state <= DONE;
               end else if (!wait_n_in) begin
                  state <= STROBE;
               end
            end
            STROBE: begin
               if (timing_sel_in == epp_pkg::TIMING_17) begin
                  if (wdog_expired || !host_active) begin
                     state <= DONE;
                  end
               end else if (wdog_expired) begin
                  state <= DONE;
               end else if (wait_n_in) begin
                  state <= HOLD;
               end
            end
            HOLD: begin
               // Bus kept until peripheral lowers wait or the watchdog expires
               if (!wait_n_in || wdog_expired) begin
                  state <= DONE;
               end
            end
            DONE: begin
               if (!host_active) begin
                  state <= IDLE;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end

   // Watchdog counts from host strobe; saturates to avoid wrap
   always_ff @(posedge clk_in) begin
      if (rst_in || state == IDLE || state == DONE) begin
         wdog <= '0;
      end else if (!wdog_expired) begin
         wdog <= wdog + 1'b1;
      end
   end

   // Set wins over software clear
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         timeout_flag_out <= 1'b0;
      end else if (state != IDLE && state != DONE && wdog_expired) begin
         timeout_flag_out <= 1'b1;
      end else if (timeout_clear_in) begin
         timeout_flag_out <= 1'b0;
      end
   end

   // Byte latches; a 1.7 write tracks the host byte while it holds
   // its strobe, since the byte is gone once the strobe drops
   assign rd_capture = port_data_in;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         latch_data <= epp_pkg::DATA_RESET;
         host_data_bus_out <= epp_pkg::DATA_RESET;
      end else begin
         if (state == IDLE && start && host_req_in.wr) begin
            latch_data <= host_req_in.wdata;
         end else if (state == STROBE && cyc_write &&
                      timing_sel_in == epp_pkg::TIMING_17 &&
                      host_active) begin
            latch_data <= host_req_in.wdata;
         end
         if (state == STROBE && !cyc_write &&
             (wait_n_in || timing_sel_in == epp_pkg::TIMING_17)) begin
            host_data_bus_out <= rd_capture;
         end
      end
   end

   assign push = (state == STROBE) && !cyc_write &&
                 (timing_sel_in == epp_pkg::TIMING_17 ? !host_active
                                                      : wait_n_in);
   assign strobe_on = (state == STROBE);
   assign data_strobe_n_out = !(strobe_on && !cyc_addr);
   assign addr_strobe_n_out = !(strobe_on && cyc_addr);

   // Ready: 1.9 held low from start until wait rises, 1.7 only while wait low
   always_comb begin
      if (timing_sel_in == epp_pkg::TIMING_17) begin
         iochrdy_out = !(state == STROBE && !wait_n_in &&
                         !wdog_expired);
      end else begin
         iochrdy_out = !(state == WAIT_LOW || state == STROBE ||
                         (state == IDLE && start));
      end
   end

   // Port pins: EPP drive in a cycle, control register otherwise
   // Waiting for wait low counts as idle: write line and data
   // must not move while the previous peripheral cycle ends
   always_comb begin
      logic epp_busy;
      logic epp_read;
      logic interlocked;
      interlocked = (timing_sel_in == epp_pkg::TIMING_19);
      epp_busy = (state != IDLE) && (state != WAIT_LOW);
      epp_read = epp_busy && !cyc_write && interlocked;
      port_dir_out = ctrl_reg_in[epp_pkg::CTRL_DIR] || epp_read;
      // 1.7 write line follows the direction bit, except that a set strobe bit in a cycle forces it low
      if (epp_busy && interlocked) begin
         write_n_out = epp_read;
      end else begin
         write_n_out = ctrl_reg_in[epp_pkg::CTRL_DIR];
      end
      if (ctrl_reg_in[epp_pkg::CTRL_STROBE] && epp_busy) begin
         port_dir_out = 1'b0;
         write_n_out = 1'b0;
      end
      port_data_oe_out = !port_dir_out;
      port_data_out = (epp_busy && cyc_write) ? latch_data
                                              : spp_data_in;
   end

   // SPP outputs untouched by EPP cycles
   assign strobe_n_out = !ctrl_reg_in[epp_pkg::CTRL_STROBE];
   assign autofd_n_out = !ctrl_reg_in[epp_pkg::CTRL_AUTOFD];
   assign slctin_n_out = !ctrl_reg_in[epp_pkg::CTRL_SLCTIN];
   assign init_n_out = ctrl_reg_in[epp_pkg::CTRL_INIT] && !rst_in;
   assign intr_out = intr_in;

   // Full FIFO stalls new cycles via start
   epp_fifo #(
      .WIDTH(epp_pkg::FIFO_WIDTH),
      .DEPTH(epp_pkg::FIFO_DEPTH)
   ) epp_fifo_i (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .in_valid_in(push),
      .in_ready_out(fifo_ready),
      .in_data_in({cyc_addr, rd_capture}),
      .out_valid_out(xfer_valid_out),
      .out_ready_in(xfer_ready_in),
      .out_data_out(xfer_out)
   );
endmodule

`default_nettype wire

// file: testbench/epp_cycle_engine_checker.sv
// Concurrent checks on the EPP cycle engine ports
`timescale 1ns/100ps
`default_nettype none
module epp_cycle_engine_checker (
   // Clock, reset and inputs
   input wire logic clk_in,
   input wire logic rst_in,
   input wire epp_pkg::timing_t timing_sel_in,
   input wire logic timeout_clear_in,
   input wire epp_pkg::host_req_t host_req_in,
   input wire logic wait_n_in,
   // Observed outputs
   input wire logic timeout_flag_out,
   input wire logic iochrdy_out,
   input wire logic write_n_out,
   input wire logic data_strobe_n_out,
   input wire logic addr_strobe_n_out,
   input wire logic port_dir_out,
   input wire logic port_data_oe_out
);
   logic t19;
   logic stb;
   logic [7:0] low_cnt;
   assign t19 = timing_sel_in == epp_pkg::TIMING_19;
   assign stb = !(data_strobe_n_out && addr_strobe_n_out);
   // A hung peripheral shows up as a long stall
   always_ff @(posedge clk_in) begin
      if (rst_in || iochrdy_out) begin
         low_cnt <= 8'h00;
      end else begin
         low_cnt <= low_cnt + 8'h01;
      end
   end
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_ready_held: assert property (t19 && stb |-> !iochrdy_out)
      else $error("ready during strobe");
   a_strobe_after_ready: assert property (
      t19 && $rose(stb) |-> !$past(wait_n_in))
      else $error("strobe before wait low");
   a_write_drive: assert property (
      stb && !write_n_out |-> port_data_oe_out && !port_dir_out)
      else $error("write bus not driven");
   a_read_float: assert property (
      t19 && stb && write_n_out |-> !port_data_oe_out && port_dir_out)
      else $error("read bus not floated");
   a_wait_ends: assert property (
      t19 && stb && wait_n_in |=> !stb && iochrdy_out)
      else $error("cycle not ended");
   // Watchdog releases ready at its limit, hence the stall bound
   a_slow_ready: assert property (
      !t19 && stb && !wait_n_in && low_cnt < 8'h64 |-> !iochrdy_out)
      else $error("ready while wait low");
   a_host_paces: assert property (
      !t19 && !(host_req_in.rd || host_req_in.wr) |=> !stb)
      else $error("strobe outlives host");
   a_watchdog_bound: assert property (low_cnt <= 8'h6A)
      else $error("stall too long");
   a_flag_clear: assert property (
      timeout_clear_in && !stb && iochrdy_out |=> !timeout_flag_out)
      else $error("flag not cleared");
endmodule
`default_nettype wire

// file: testbench/epp_periph_model.sv
// Behavioural EPP peripheral on the far side of the cable
`timescale 1ns/100ps
`default_nettype none
module epp_periph_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Cable from the engine
   input wire logic data_strobe_n_in,
   input wire logic addr_strobe_n_in,
   input wire logic write_n_in,
   input wire logic [7:0] port_data_in,
   // Bench controls
   input wire logic [7:0] rd_byte_in,
   input wire logic [3:0] dly_in,
   input wire logic busy_in,
   input wire logic mute_in,
   // Cable to the engine
   output logic wait_n_out,
   output logic [7:0] port_data_out,
   output logic [7:0] got_out
);
   logic stb;
   logic drv;
   logic [3:0] cnt;
   assign stb = !(data_strobe_n_in && addr_strobe_n_in);
   // Released bus shows the inverse, never a stale byte
   assign port_data_out = drv ? rd_byte_in : ~rd_byte_in;
   always_ff @(posedge clk_in) begin
      if (rst_in || !stb) begin
         cnt <= 4'h0;
         drv <= 1'b0;
         wait_n_out <= busy_in;
      end else if (!mute_in) begin
         cnt <= cnt + 4'h1;
         drv <= write_n_in;
         if (cnt == dly_in) begin
            wait_n_out <= 1'b1;
         end
      end
      if (stb && !write_n_in) begin
         got_out <= port_data_in;
      end
   end
endmodule
`default_nettype wire

// file: testbench/test_epp_cycle_engine.sv
// Self-checking bench for the EPP cycle engine
`timescale 1ns/100ps
`default_nettype none
module test_epp_cycle_engine;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   epp_pkg::timing_t tsel = epp_pkg::TIMING_19;
   epp_pkg::host_req_t req = '0;
   epp_pkg::xfer_t xout;
   logic [5:0] ctrl = 6'h00;
   logic en = 1'b1;
   logic clr = 1'b0, intr = 1'b0, xrdy = 1'b0, busy = 1'b0, mute = 1'b0;
   logic [7:0] rd_byte = 8'h00;
   logic [3:0] dly = 4'h2;
   logic rdy, flag, intr_o, wr_n, ds_n, as_n, dir, oe, xval, wait_n;
   logic stb_n, afd_n, ini_n, sel_n;
   logic [7:0] hdat, pout, pin, got, rdat;
   int errors = 0;
   int total_checks = 0;
   int cycles = 0;
   epp_cycle_engine epp_cycle_engine_i (.clk_in(clk_in), .rst_in(rst_in),
      .epp_enable_in(en), .timing_sel_in(tsel), .ctrl_reg_in(ctrl),
      .spp_data_in(8'h3C), .timeout_clear_in(clr), .timeout_flag_out(flag),
      .host_req_in(req), .iochrdy_out(rdy), .host_data_bus_out(hdat),
      .wait_n_in(wait_n), .intr_in(intr), .intr_out(intr_o),
      .write_n_out(wr_n), .data_strobe_n_out(ds_n), .addr_strobe_n_out(as_n),
      .port_dir_out(dir), .init_n_out(ini_n), .strobe_n_out(stb_n),
      .autofd_n_out(afd_n), .slctin_n_out(sel_n), .port_data_in(pin),
      .port_data_out(pout), .port_data_oe_out(oe), .xfer_valid_out(xval),
      .xfer_ready_in(xrdy), .xfer_out(xout));
   epp_periph_model epp_periph_model_i (.clk_in(clk_in), .rst_in(rst_in),
      .data_strobe_n_in(ds_n), .addr_strobe_n_in(as_n), .write_n_in(wr_n),
      .port_data_in(pout), .rd_byte_in(rd_byte), .dly_in(dly),
      .busy_in(busy), .mute_in(mute), .wait_n_out(wait_n),
      .port_data_out(pin), .got_out(got));
   always #50 clk_in = ~clk_in;
   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Longest run is under a thousand cycles
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] act, input logic [7:0] exp);
      total_checks++;
      if (act !== exp) begin
         errors++;
         $display("FAIL %0t got %h want %h", $time, act, exp);
      end
   endtask
   // Host cycle held for hold+2 cycles and then until ready, then dropped for two cycles
   task automatic cyc(input logic rd, input logic [2:0] ofs,
         input logic [7:0] wd, input int hold);
      int n;
      n = 0;
      @(posedge clk_in);
      req <= '{rd: rd, wr: !rd, offset: ofs, wdata: wd};
      repeat (hold + 2) @(posedge clk_in);
      while (rdy !== 1'b1 && n < 300) begin
         @(posedge clk_in);
         n++;
      end
      rdat = hdat;
      req <= '0;
      repeat (2) @(posedge clk_in);
   endtask
   initial begin
      repeat (2) @(posedge clk_in);
      rst_in <= 1'b0;
      busy <= 1'b1;
      fork
         cyc(1'b0, 3'h3, 8'hA5, 0);
         begin
            repeat (6) @(posedge clk_in);
            chk({7'h0, as_n}, 8'h01);
            busy <= 1'b0;
         end
      join
      chk(got, 8'hA5);
      for (int i = 4; i < 8; i++) begin
         cyc(1'b0, 3'(i), 8'h10 + 8'(i), 0);
         chk(got, 8'h10 + 8'(i));
      end
      cyc(1'b0, 3'h1, 8'h77, 0);
      chk(got, 8'h17);
      en <= 1'b0;
      cyc(1'b0, 3'h4, 8'h42, 0);
      chk(got, 8'h17);
      en <= 1'b1;
      for (int i = 0; i < 33; i++) begin
         rd_byte <= (i == 32) ? 8'hEE : 8'(i);
         dly <= 4'(i % 4 + 1);
         cyc(1'b1, i[0] ? 3'h4 : 3'h3, 8'h00, 0);
         if (i < 32) begin
            chk(rdat, 8'(i));
         end
      end
      xrdy <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         @(posedge clk_in);
         chk({xval, xout.is_addr, xout.data[5:0]},
            {1'b1, !i[0], 6'(i)});
      end
      @(posedge clk_in);
      chk({7'h0, xval}, 8'h00);
      mute <= 1'b1;
      cyc(1'b0, 3'h4, 8'h5A, 0);
      chk({7'h0, flag}, 8'h01);
      mute <= 1'b0;
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      @(posedge clk_in);
      chk({7'h0, flag}, 8'h00);
      tsel <= epp_pkg::TIMING_17;
      cyc(1'b0, 3'h4, 8'hC3, 5);
      chk(got, 8'hC3);
      ctrl <= 6'h20;
      cyc(1'b1, 3'h4, 8'h00, 5);
      chk(rdat, 8'hEE);
      chk({6'h0, dir, wr_n}, 8'h03);
      ctrl <= 6'h00;
      cyc(1'b0, 3'h5, 8'h99, 120);
      chk({7'h0, flag}, 8'h01);
      for (int b = 0; b < 4; b++) begin
         ctrl <= 6'(1 << b);
         repeat (2) @(posedge clk_in);
         chk({4'h0, sel_n, ini_n, afd_n, stb_n},
            {4'h0, b != 3, b == 2, b != 1, b != 0});
      end
      chk(pout, 8'h3C);
      intr <= 1'b1;
      repeat (2) @(posedge clk_in);
      chk({7'h0, intr_o}, 8'h01);
      give_verdict();
   end
endmodule
bind epp_cycle_engine epp_cycle_engine_checker epp_cycle_engine_checker_i (
   .clk_in(clk_in), .rst_in(rst_in), .timing_sel_in(timing_sel_in),
   .timeout_clear_in(timeout_clear_in), .host_req_in(host_req_in),
   .wait_n_in(wait_n_in), .timeout_flag_out(timeout_flag_out),
   .iochrdy_out(iochrdy_out), .write_n_out(write_n_out),
   .data_strobe_n_out(data_strobe_n_out),
   .addr_strobe_n_out(addr_strobe_n_out), .port_dir_out(port_dir_out),
   .port_data_oe_out(port_data_oe_out));
`default_nettype wire
